// [clk_setup_pkg.sv]
package clk_setup_pkg;

  // Register byte addresses on the bus
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] MODE_OFFSET   = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] SAMPLE_OFFSET = 8'h0c;

  // Control register field positions
  localparam int CTRL_REF_POWER_BIT = 0;
  localparam int CTRL_PLL_POWER_BIT = 1;
  localparam int CTRL_MASTER_BIT    = 2;
  localparam int CTRL_MCLK_OUT_BIT  = 3;

  // Mode register field positions
  localparam int MODE_FMT_LSB     = 0;
  localparam int MODE_PLLREF_LSB  = 2;
  localparam int MODE_RATE_LSB    = 6;
  localparam int MODE_BCKRATE_BIT = 10;
  localparam int MODE_DIV_LSB     = 12;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Divider 00 selects 256fs output
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  // Reference selection codes (pll_reference_sel)
  localparam logic [3:0] REF_FRAME = 4'h0;
  localparam logic [3:0] REF_BIT   = 4'h1;

  // Worst-case lock times
  localparam int LOCK_MCLK_MS  = 40;
  localparam int LOCK_FRAME_MS = 160;
  localparam int LOCK_BIT_MS   = 2;
  localparam int CLK_MHZ       = 125;
  localparam int CYC_PER_MS    = CLK_MHZ * 1000;
  localparam int LOCK_MCLK_CYC  = LOCK_MCLK_MS * CYC_PER_MS;
  localparam int LOCK_FRAME_CYC = LOCK_FRAME_MS * CYC_PER_MS;
  localparam int LOCK_BIT_CYC   = LOCK_BIT_MS * CYC_PER_MS;

  // Reference counted as present after this many edges seen
  localparam int PRESENT_EDGES = 4;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_WAIT = 2'b01,
    ST_LOCK = 2'b10,
    ST_RUN  = 2'b11
  } pll_state_t;

  typedef struct packed {
    logic       ref_power;
    logic       pll_power;
    logic       master;
    logic       mclk_out_en;
    logic [1:0] format;
    logic [3:0] pll_ref;
    logic [3:0] rate;
    logic       bck_rate;
    logic [1:0] mclk_div;
  } clk_cfg_t;

endpackage : clk_setup_pkg

// [edge_sync.sv]
`timescale 1ns/1ps
module edge_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic [1:0] prime_reg;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else if (ce)
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Edges count only once the history flop holds a real sample, so a pin
  // resting high on its pull-up does not look like a rising edge after reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      prime_reg <= 2'h0;
    else if (ce && prime_reg != 2'h3)
      prime_reg <= prime_reg + 2'h1;
  end

  assign rise = ce & prime_reg[1] & prime_reg[0] & sync_reg & ~last_reg;
endmodule : edge_sync

// [codec_clock_setup_sequencer.sv]
//Contract
// - PLL power bit zero selects external clock mode, one PLL mode.
// - Master mode PLL locks within 40ms of PLL power rising.
// - Master mode frame and bit clocks start only after lock.
// - Master clock output invalid before lock, valid after, off when disabled.
// - Slave PLL starts only after power rise and reference present.
// - Slave lock within 160ms on frame clock, 2ms on bit clock.
// - Frame and bit clock pins undriven until master bit set.
// - DAC samples two's complement; 7fff max, 8000 min full scale.
// - Rate field sets PLL sample rate or expected input clock rate.
// - Two-bit divider sets master clock output rate, default 256fs.
`timescale 1ns/1ps
module codec_clock_setup_sequencer #(
  parameter int LOCK_MCLK  = clk_setup_pkg::LOCK_MCLK_CYC,
  parameter int LOCK_FRAME = clk_setup_pkg::LOCK_FRAME_CYC,
  parameter int LOCK_BIT   = clk_setup_pkg::LOCK_BIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_clock_in,
  input  wire logic        frame_clock_in,
  input  wire logic        serial_bit_clock_in,
  output logic             frame_clock_oe,
  output logic             serial_bit_clock_oe,
  output logic             serial_clk_gate,
  output logic             master_clock_out_en,
  output logic             master_clock_out_valid,
  output logic             external_clock_mode,
  output logic             common_ref_power,
  output logic             clocks_ok,
  output logic [3:0]       rate_select,
  output logic [1:0]       mclk_out_divider,
  output logic signed [15:0] dac_level
);
  import clk_setup_pkg::*;

  clk_setup_pkg::clk_cfg_t cfg_reg;
  pll_state_t              st_reg;
  logic [31:0]             lock_cnt_reg;
  logic [31:0]             lock_lim;
  logic                    pll_pwr_last_reg;
  logic [2:0]              mck_seen_reg;
  logic [2:0]              frm_seen_reg;
  logic [2:0]              bck_seen_reg;
  logic                    mck_rise;
  logic                    frm_rise;
  logic                    bck_rise;
  logic                    ref_present;
  logic                    locked;
  logic                    pll_rise;
  logic                    wr_en;
  logic [15:0]             sample_reg;

  // Slave mode uses the pll_reference code; master mode always locks to the input clock
  edge_sync u_mck (.clk(clk), .sys_rst(sys_rst), .ce(ce), .async_in(master_clock_in),
                   .rise(mck_rise));
  edge_sync u_frm (.clk(clk), .sys_rst(sys_rst), .ce(ce), .async_in(frame_clock_in),
                   .rise(frm_rise));
  edge_sync u_bck (.clk(clk), .sys_rst(sys_rst), .ce(ce), .async_in(serial_bit_clock_in),
                   .rise(bck_rise));

  assign wr_en    = psel & penable & pwrite & ce;
  assign pll_rise = cfg_reg.pll_power & ~pll_pwr_last_reg;
  assign locked   = (st_reg == ST_RUN);

  // Register writes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_reg    <= '0;
      sample_reg <= 16'h0000;
    end
    else if (wr_en)
    begin
      case (paddr)
        CTRL_OFFSET:
        begin
          cfg_reg.ref_power   <= pwdata[CTRL_REF_POWER_BIT];
          cfg_reg.pll_power   <= pwdata[CTRL_PLL_POWER_BIT];
          cfg_reg.master      <= pwdata[CTRL_MASTER_BIT];
          cfg_reg.mclk_out_en <= pwdata[CTRL_MCLK_OUT_BIT];
        end
        MODE_OFFSET:
        begin
          cfg_reg.format   <= pwdata[MODE_FMT_LSB +: 2];
          cfg_reg.pll_ref  <= pwdata[MODE_PLLREF_LSB +: 4];
          cfg_reg.rate     <= pwdata[MODE_RATE_LSB +: 4];
          cfg_reg.bck_rate <= pwdata[MODE_BCKRATE_BIT];
          cfg_reg.mclk_div <= pwdata[MODE_DIV_LSB +: 2];
        end
        SAMPLE_OFFSET: sample_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read path answers in the access cycle; unmapped addresses give slverr
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == CTRL_OFFSET || paddr == MODE_OFFSET ||
                                     paddr == STATUS_OFFSET || paddr == SAMPLE_OFFSET);
      prdata  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite)
      begin
        case (paddr)
          CTRL_OFFSET:   prdata <= {28'h0, cfg_reg.mclk_out_en, cfg_reg.master,
                                    cfg_reg.pll_power, cfg_reg.ref_power};
          MODE_OFFSET:   prdata <= {18'h0, cfg_reg.mclk_div, 1'b0, cfg_reg.bck_rate,
                                    cfg_reg.rate, cfg_reg.pll_ref, cfg_reg.format};
          STATUS_OFFSET: prdata <= {28'h0, ref_present, locked, st_reg};
          SAMPLE_OFFSET: prdata <= {16'h0, sample_reg};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Saturating edge counters mark a reference as present; sticky until reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mck_seen_reg <= 3'h0;
      frm_seen_reg <= 3'h0;
      bck_seen_reg <= 3'h0;
    end
    else if (ce)
    begin
      if (mck_rise && mck_seen_reg != 3'(PRESENT_EDGES))
        mck_seen_reg <= mck_seen_reg + 3'h1;
      if (frm_rise && frm_seen_reg != 3'(PRESENT_EDGES))
        frm_seen_reg <= frm_seen_reg + 3'h1;
      if (bck_rise && bck_seen_reg != 3'(PRESENT_EDGES))
        bck_seen_reg <= bck_seen_reg + 3'h1;
    end
  end

  always_comb
  begin
    if (cfg_reg.master)
    begin
      ref_present = (mck_seen_reg == 3'(PRESENT_EDGES));
      lock_lim    = 32'(LOCK_MCLK);
    end
    else if (cfg_reg.pll_ref == REF_FRAME)
    begin
      ref_present = (frm_seen_reg == 3'(PRESENT_EDGES));
      lock_lim    = 32'(LOCK_FRAME);
    end
    else if (cfg_reg.pll_ref == REF_BIT)
    begin
      ref_present = (bck_seen_reg == 3'(PRESENT_EDGES));
      lock_lim    = 32'(LOCK_BIT);
    end
    else
    begin
      ref_present = (mck_seen_reg == 3'(PRESENT_EDGES));
      lock_lim    = 32'(LOCK_MCLK);
    end
  end

  // PLL start and lock timer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_reg           <= ST_OFF;
      lock_cnt_reg     <= 32'h0;
      pll_pwr_last_reg <= 1'b0;
    end
    else if (ce)
    begin
      pll_pwr_last_reg <= cfg_reg.pll_power;
      case (st_reg)
        ST_OFF:
          if (pll_rise)
            st_reg <= ST_WAIT;
        ST_WAIT:
          if (!cfg_reg.pll_power)
            st_reg <= ST_OFF;
          else if (ref_present)
          begin
            st_reg       <= ST_LOCK;
            lock_cnt_reg <= 32'h0;
          end
        ST_LOCK:
          if (!cfg_reg.pll_power)
            st_reg <= ST_OFF;
          else if (lock_cnt_reg >= lock_lim - 32'h1)
            st_reg <= ST_RUN;
          else
            lock_cnt_reg <= lock_cnt_reg + 32'h1;
        ST_RUN:
          if (!cfg_reg.pll_power)
            st_reg <= ST_OFF;
        default: st_reg <= ST_OFF;
      endcase
    end
  end

  // Outputs all registered; master clock output may run before lock but is flagged invalid
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      frame_clock_oe         <= 1'b0;
      serial_bit_clock_oe    <= 1'b0;
      serial_clk_gate        <= 1'b0;
      master_clock_out_en    <= 1'b0;
      master_clock_out_valid <= 1'b0;
      external_clock_mode    <= 1'b1;
      common_ref_power       <= 1'b0;
      clocks_ok              <= 1'b0;
      rate_select            <= 4'h0;
      mclk_out_divider       <= 2'h0;
      dac_level              <= 16'sh0000;
    end
    else if (ce)
    begin
      frame_clock_oe         <= cfg_reg.master;
      serial_bit_clock_oe    <= cfg_reg.master;
      serial_clk_gate        <= cfg_reg.master & cfg_reg.pll_power & locked;
      master_clock_out_en    <= cfg_reg.mclk_out_en & cfg_reg.pll_power;
      master_clock_out_valid <= cfg_reg.mclk_out_en & cfg_reg.pll_power & locked;
      external_clock_mode    <= ~cfg_reg.pll_power;
      common_ref_power       <= cfg_reg.ref_power;
      clocks_ok              <= cfg_reg.pll_power ? locked :
                                (mck_seen_reg == 3'(PRESENT_EDGES)) &
                                (frm_seen_reg == 3'(PRESENT_EDGES)) &
                                (bck_seen_reg == 3'(PRESENT_EDGES));
      rate_select            <= cfg_reg.rate;
      mclk_out_divider       <= cfg_reg.mclk_div;
      dac_level              <= signed'(sample_reg);
    end
  end

  property no_serial_before_lock;
    @(posedge clk) disable iff (sys_rst)
      serial_clk_gate |-> $past(locked);
  endproperty
  serial_gate_lock_a: assert property (no_serial_before_lock)
    else $error("serial clocks ungated before lock");

  mclk_valid_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    master_clock_out_valid |-> master_clock_out_en && $past(locked))
    else $error("master clock valid without enable");

  pins_undriven_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && !cfg_reg.master) |=> !frame_clock_oe && !serial_bit_clock_oe)
    else $error("serial pins driven in slave");

  sequence ref_wait_s;
    st_reg == ST_WAIT && !ref_present && cfg_reg.pll_power;
  endsequence
  pll_start_ref_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ref_wait_s and ce) |=> st_reg != ST_LOCK)
    else $error("pll started without reference");

  clock_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce |=> external_clock_mode == !$past(cfg_reg.pll_power))
    else $error("clock mode mismatch");

  lock_timer_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_reg == ST_LOCK && $past(st_reg) == ST_WAIT) |-> lock_cnt_reg == 32'h0)
    else $error("lock timer not cleared");

  lock_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_reg == ST_LOCK |-> lock_cnt_reg < lock_lim)
    else $error("lock timer overran limit");

  divider_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce |=> mclk_out_divider == $past(cfg_reg.mclk_div))
    else $error("divider not applied");

  rate_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce |=> rate_select == $past(cfg_reg.rate))
    else $error("rate not applied");

  dac_sign_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && sample_reg == 16'h8000) |=> dac_level < 0)
    else $error("negative full scale misread");

  slave_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!cfg_reg.master && cfg_reg.pll_ref == REF_BIT) |-> lock_lim == 32'(LOCK_BIT))
    else $error("bit clock lock limit wrong");

endmodule : codec_clock_setup_sequencer

// [clock_partner.sv]
`timescale 1ns/1ps
module clock_partner (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic mclk_en,
  input  wire logic bck_en,
  input  wire logic frm_en,
  input  wire logic frame_clock_oe,
  input  wire logic serial_bit_clock_oe,
  output logic      master_clock_in,
  output logic      frame_clock_in,
  output logic      serial_bit_clock_in
);
  logic [4:0] div_reg;

  // One divider feeds all three clocks so they stay phase related
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_reg <= 5'h00;
    else
      div_reg <= div_reg + 5'h01;
  end

  // Clocks stand still between uses; released frame and bit clock pins float up to the pull-up level, master clock rests low
  assign master_clock_in     = mclk_en & div_reg[1];
  assign serial_bit_clock_in = serial_bit_clock_oe ? 1'b1 : (bck_en ? div_reg[2] : 1'b1);
  assign frame_clock_in      = frame_clock_oe ? 1'b1 : (frm_en ? div_reg[4] : 1'b1);
endmodule : clock_partner

// [codec_clock_setup_sequencer_bench.sv]
`timescale 1ns/1ps
module codec_clock_setup_sequencer_bench;
  import clk_setup_pkg::*;
  localparam int LM = 50;
  localparam int LF = 200;
  localparam int LB = 10;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic        eexp;
    logic [21:0] pexp;
  } row_t;
  typedef struct packed {
    logic [3:0]  ref_sel;
    logic        master;
    logic [15:0] lim;
    logic [15:0] per;
  } lock_t;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        mck_en = 1'b0;
  logic        bck_en = 1'b0;
  logic        frm_en = 1'b0;
  logic [31:0] prdata, rd, c;
  logic        pready, pslverr, mck, frm, bck, frm_oe, bck_oe, gate, er;
  logic        mco_en, mco_ok, xclk_mode, ref_pwr, ok;
  logic [3:0]  rate;
  logic [1:0]  div;
  logic signed [15:0] dac;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          n;
  row_t  rows [5] = '{
    '{MODE_OFFSET, 32'h0000_3683, 32'h0000_3683, 1'b0, {4'ha, 2'h3, 16'h0000}},
    '{SAMPLE_OFFSET, 32'hffff_7fff, 32'h0000_7fff, 1'b0, {4'ha, 2'h3, 16'h7fff}},
    '{SAMPLE_OFFSET, 32'h0000_8000, 32'h0000_8000, 1'b0, {4'ha, 2'h3, 16'h8000}},
    '{8'h10, 32'hffff_ffff, 32'h0000_0000, 1'b1, {4'ha, 2'h3, 16'h8000}},
    '{MODE_OFFSET, 32'h0000_1140, 32'h0000_1140, 1'b0, {4'h5, 2'h1, 16'h8000}}};
  lock_t lk [4] = '{'{4'h2, 1'b1, 16'(LM), 16'd4}, '{REF_BIT, 1'b0, 16'(LB), 16'd8},
                    '{REF_FRAME, 1'b0, 16'(LF), 16'd32}, '{4'h2, 1'b0, 16'(LM), 16'd4}};

  initial forever #4 clk = ~clk;

  codec_clock_setup_sequencer #(.LOCK_MCLK(LM), .LOCK_FRAME(LF), .LOCK_BIT(LB)) dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clock_in(mck), .frame_clock_in(frm), .serial_bit_clock_in(bck),
    .frame_clock_oe(frm_oe), .serial_bit_clock_oe(bck_oe), .serial_clk_gate(gate),
    .master_clock_out_en(mco_en), .master_clock_out_valid(mco_ok),
    .external_clock_mode(xclk_mode), .common_ref_power(ref_pwr), .clocks_ok(ok),
    .rate_select(rate), .mclk_out_divider(div), .dac_level(dac));

  clock_partner partner (
    .clk(clk), .sys_rst(sys_rst), .mclk_en(mck_en), .bck_en(bck_en), .frm_en(frm_en),
    .frame_clock_oe(frm_oe), .serial_bit_clock_oe(bck_oe), .master_clock_in(mck),
    .frame_clock_in(frm), .serial_bit_clock_in(bck));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reset_dut(input int cyc);
    @(posedge clk);
    sys_rst <= 1'b1;
    {mck_en, bck_en, frm_en} <= 3'b000;
    repeat (cyc) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : reset_dut

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic wait_ok(input int hi);
    @(posedge clk);
    {mck_en, bck_en, frm_en} <= 3'b111;
    n = 0;
    while (ok !== 1'b1 && n < hi)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_ok

  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end

  initial
  begin
    reset_dut(2);
    settle();
    chk(xclk_mode, 1);
    chk({ref_pwr, ok, gate, mco_ok, frm_oe, bck_oe, div}, 0);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(rd, CTRL_RESET);
    apb(1'b0, MODE_OFFSET, 32'h0);
    chk(rd, MODE_RESET);
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].addr, rows[i].wdata);
      apb(1'b0, rows[i].addr, 32'h0);
      chk(rd, rows[i].rexp);
      chk(32'(er), 32'(rows[i].eexp));
      chk(32'({rate, div, dac}), 32'(rows[i].pexp));
    end
    foreach (lk[i])
    begin
      reset_dut(19);
      apb(1'b1, MODE_OFFSET, 32'(lk[i].ref_sel) << MODE_PLLREF_LSB);
      c = (32'h1 << CTRL_REF_POWER_BIT) | (32'h1 << CTRL_MCLK_OUT_BIT);
      c = c | (32'(lk[i].master) << CTRL_MASTER_BIT);
      apb(1'b1, CTRL_OFFSET, c);
      settle();
      chk({frm_oe, bck_oe}, {2{lk[i].master}});
      apb(1'b1, CTRL_OFFSET, c | (32'h1 << CTRL_PLL_POWER_BIT));
      repeat (40) @(posedge clk);
      #1;
      chk({xclk_mode, ok, gate, mco_ok, mco_en}, 5'b00001);
      wait_ok(32'(lk[i].lim) + 4 * 32'(lk[i].per) + 16);
      #1;
      chk(32'(n >= 32'(lk[i].lim)), 1);
      chk(ok, 1);
      chk({gate, mco_ok}, {lk[i].master, 1'b1});
    end
    reset_dut(19);
    apb(1'b1, CTRL_OFFSET, 32'h1 << CTRL_REF_POWER_BIT);
    settle();
    chk({ref_pwr, xclk_mode, ok}, 3'b110);
    wait_ok(4 * 32 + 16);
    #1;
    chk({ok, gate}, 2'b10);
    // Clock enable low must freeze the synchronisers and the lock timer
    reset_dut(19);
    apb(1'b1, MODE_OFFSET, 32'(REF_BIT) << MODE_PLLREF_LSB);
    c = (32'h1 << CTRL_REF_POWER_BIT) | (32'h1 << CTRL_PLL_POWER_BIT);
    apb(1'b1, CTRL_OFFSET, c);
    @(posedge clk);
    ce <= 1'b0;
    {mck_en, bck_en, frm_en} <= 3'b111;
    repeat (LB + 4 * 8 + 40) @(posedge clk);
    #1;
    chk({ok, gate, xclk_mode}, 3'b000);
    @(posedge clk);
    ce <= 1'b1;
    wait_ok(LB + 4 * 8 + 16);
    #1;
    chk(ok, 1);
    test_done();
  end
endmodule : codec_clock_setup_sequencer_bench
